/* logic/padc_pkg.sv */
// Shared constants for the pipelined converter digital back end.
package padc_pkg;
  localparam int        RES_BITS     = 10;
  localparam int        NUM_STAGES   = 8;
  localparam int        STAGE_BITS   = 2;
  localparam int        ALIGN_BITS   = (NUM_STAGES + 1) * STAGE_BITS;
  localparam int        LATENCY      = 6;
  localparam int        CLK_NS       = 10;
  localparam int        LAT_CYC      = LATENCY;
  localparam logic [9:0] MID_CODE    = 10'h200;
  localparam logic [9:0] RESULT_RST  = 10'h000;
  localparam logic [1:0] PHASE_RST   = 2'h1;
  typedef enum logic [1:0] {
    PADC_SAMPLE = 2'b01,
    PADC_HOLD   = 2'b10
  } padc_phase_e;
endpackage

/* logic/padc_skid.sv */
// Two-entry valid/ready buffer carrying one result word pair.
`timescale 1ns/1ps
module padc_skid #(
  parameter int W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem [2];
  logic         wrPtr;
  logic         rdPtr;
  logic [1:0]   count;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (inValid && inReady) begin
        wrPtr <= ~wrPtr;
      end
      if (outValid && outReady) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, inValid && inReady} - {1'b0, outValid && outReady};
    end
  end
endmodule

/* logic/padc_backend.sv */
// Dual-channel pipelined converter back end: stage alignment, correction, output.
//
// Behaviour
// - Two independent channels, ten-bit words each, one shared sampling clock.
// - Each channel: eight two-bit pipeline stages plus a two-bit flash stage.
// - Each pipeline stage emits two bits, one redundant for correction.
// - Delay line aligns all stage codes into one eighteen-bit word.
// - Correction adds overlapped stage codes, yielding the ten-bit result.
// - Result for a sample appears six clocks after its flash-stage code arrives, fourteen after its first-stage code.
// - After latency, one new word every clock cycle while resultReady is high.
// - Non-overlapping sample and hold phases derived from the sampling clock.
// - Input captured at end of sample phase; hold phase completes it.
// - Adjacent stages run on opposite phases, alternating operations.
// - Offset binary, bit 9 MSB, all ones at top, 0x200 just above zero.
// - Just below zero differential input gives 0x1ff.
`timescale 1ns/1ps
module padc_backend #(
  parameter int LAT = padc_pkg::LAT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [17:0] iStageCode,
  input  wire logic [17:0] qStageCode,
  output padc_pkg::padc_phase_e phase,
  output logic             sampleEn,
  output logic [9:0]       iResult,
  output logic [9:0]       qResult,
  output logic             resultValid,
  input  wire logic        resultReady
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Stage codes come from the analog core, so they pass two flops first.
  logic [17:0] iMeta;
  logic [17:0] qMeta;
  logic [17:0] iCode;
  logic [17:0] qCode;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iMeta <= '0;
      qMeta <= '0;
      iCode <= '0;
      qCode <= '0;
    end else begin
      iMeta <= iStageCode;
      qMeta <= qStageCode;
      iCode <= iMeta;
      qCode <= qMeta;
    end
  end

  // ----------------------------------------------------------------------
  // Phase generation
  // ----------------------------------------------------------------------
  // Phase alternates each rising edge; the enable marks only the sample phase,
  // so the two phases can never be active together.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= padc_pkg::PADC_SAMPLE;
    end else begin
      phase <= (phase == padc_pkg::PADC_SAMPLE) ? padc_pkg::PADC_HOLD
                                                : padc_pkg::PADC_SAMPLE;
    end
  end
  assign sampleEn = (phase == padc_pkg::PADC_SAMPLE);

  // ----------------------------------------------------------------------
  // Alignment delay line
  // ----------------------------------------------------------------------
  // Stage k code is delayed by (8-k) so all nine codes meet one sample.
  logic [1:0] iDly [9][9];
  logic [1:0] qDly [9][9];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < 9; s++) begin
        for (int d = 0; d < 9; d++) begin
          iDly[s][d] <= 2'h0;
          qDly[s][d] <= 2'h0;
        end
      end
    end else begin
      for (int s = 0; s < 9; s++) begin
        iDly[s][0] <= iCode[17-2*s -: 2];
        qDly[s][0] <= qCode[17-2*s -: 2];
        for (int d = 1; d < 9; d++) begin
          iDly[s][d] <= iDly[s][d-1];
          qDly[s][d] <= qDly[s][d-1];
        end
      end
    end
  end

  function automatic logic [17:0] align(input logic [1:0] dl [9][9]);
    logic [17:0] w;
    w = '0;
    for (int s = 0; s < 9; s++) begin
      w[17-2*s -: 2] = dl[s][8-s];
    end
    return w;
  endfunction

  logic [17:0] iAligned;
  logic [17:0] qAligned;

  assign iAligned = align(iDly);
  assign qAligned = align(qDly);

  // ----------------------------------------------------------------------
  // Error correction
  // ----------------------------------------------------------------------
  // Each stage weighs one bit less than the last; overlapping one bit lets
  // the redundant bit absorb stage decision errors.  Saturate at full scale.
  function automatic logic [9:0] correct(input logic [17:0] w);
    logic [10:0] acc;
    acc = '0;
    for (int s = 0; s < 9; s++) begin
      acc = acc + (11'(w[17-2*s -: 2]) << (8 - s));
    end
    if (acc[10]) begin
      acc = 11'h3ff;
    end
    return acc[9:0];
  endfunction

  // ----------------------------------------------------------------------
  // Output timing
  // ----------------------------------------------------------------------
  // Corrected pair enters the buffer; buffer register adds the last stage.
  logic [19:0] corr;
  logic [19:0] bufOut;
  logic        bufValid;
  logic        bufInReady;
  logic        outLoad;

  // The output register only takes a new pair once the shown pair is accepted.
  // Reloading it during a stall would repeat or skip a word at the receiver.
  assign outLoad = !resultValid || resultReady;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      corr <= {padc_pkg::RESULT_RST, padc_pkg::RESULT_RST};
    end else begin
      corr <= {correct(iAligned), correct(qAligned)};
    end
  end

  padc_skid #(
    .W(20)
  ) u_skid (
    .clk     (clk),
    .rst_b   (rst_b),
    .inValid (1'b1),
    .inReady (bufInReady),
    .inData  (corr),
    .outValid(bufValid),
    .outReady(outLoad),
    .outData (bufOut)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iResult     <= padc_pkg::RESULT_RST;
      qResult     <= padc_pkg::RESULT_RST;
      resultValid <= 1'b0;
    end else if (outLoad) begin
      iResult     <= bufOut[19:10];
      qResult     <= bufOut[9:0];
      resultValid <= bufValid;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_phase_alternate: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> phase != $past(phase)) else $error("Phase did not alternate.");
  chk_sample_hold: assert property (@(posedge clk) disable iff (!rst_b)
    sampleEn |=> !sampleEn) else $error("Sample phase lasted two cycles.");
  chk_stage_invert: assert property (@(posedge clk) disable iff (!rst_b)
    sampleEn |-> ##1 (phase == padc_pkg::PADC_HOLD) ##1 sampleEn)
    else $error("Stage phases not inverted.");
  chk_align_top: assert property (@(posedge clk) disable iff (!rst_b)
    iAligned[17:16] == $past(iDly[0][7])) else $error("Top stage misaligned.");
  chk_align_flash: assert property (@(posedge clk) disable iff (!rst_b)
    qAligned[1:0] == qDly[8][0]) else $error("Flash stage misaligned.");
  chk_mid_code: assert property (@(posedge clk) disable iff (!rst_b)
    (iAligned == 18'h20000) |=> corr[19:10] == padc_pkg::MID_CODE)
    else $error("Mid code wrong.");
  chk_below_mid: assert property (@(posedge clk) disable iff (!rst_b)
    (qAligned == 18'h15555) |=> corr[9:0] == 10'h1ff)
    else $error("Below-mid code wrong.");
  chk_full_scale: assert property (@(posedge clk) disable iff (!rst_b)
    (iAligned == 18'h3ffff) |=> corr[19:10] == 10'h3ff)
    else $error("Full-scale code did not saturate.");
  chk_stream_rate: assert property (@(posedge clk) disable iff (!rst_b)
    (bufValid && resultReady) |=> resultValid) else $error("Stream stalled.");
  chk_pair_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (resultReady && bufValid) |=> {iResult, qResult} == $past(bufOut))
    else $error("Channel pair split.");
endmodule

/* dv/padc_rx_model.sv */
// Receiving logic model that captures simultaneous result pairs after power-up settling.
`timescale 1ns/1ps
module padc_rx_model #(
  parameter int SETTLE = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       stall,
  input  wire logic       resultValid,
  input  wire logic [9:0] iResult,
  input  wire logic [9:0] qResult,
  output logic            resultReady,
  output logic [9:0]      pairI,
  output logic [9:0]      pairQ
);
  int age;

  assign resultReady = !stall;

  // Words seen before the pipeline has filled are garbage, so they are never captured.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age   <= 0;
      pairI <= 10'h000;
      pairQ <= 10'h000;
    end else if (age < SETTLE) begin
      age <= age + 1;
    end else if (resultValid && resultReady) begin
      pairI <= iResult;
      pairQ <= qResult;
    end
  end
endmodule

/* dv/padc_backend_tb.sv */
// Self-checking bench for the converter back end with a receiving model.
`timescale 1ns/1ps
module padc_backend_tb;
  logic                  clk        = 1'b0;
  logic                  rst_b      = 1'b0;
  logic [17:0]           iStageCode = 18'h00000;
  logic [17:0]           qStageCode = 18'h00000;
  logic                  stall      = 1'b0;
  padc_pkg::padc_phase_e phase;
  logic                  sampleEn;
  logic                  resultValid;
  logic                  resultReady;
  logic [9:0]            iResult;
  logic [9:0]            qResult;
  logic [9:0]            pairI;
  logic [9:0]            pairQ;
  logic [9:0]            held;
  int                    errors   = 0;
  int                    compares = 0;
  int                    cycles   = 0;
  int                    seed     = 32'hd7394a64;
  logic [17:0]           corner [4] = '{18'h00000, 18'h20000, 18'h15555, 18'h3ffff};
  logic [9:0]            cornerExp [4] = '{10'h000, 10'h200, 10'h1ff, 10'h3ff};

  padc_backend u_padc_backend (.clk(clk), .rst_b(rst_b), .iStageCode(iStageCode),
    .qStageCode(qStageCode), .phase(phase), .sampleEn(sampleEn), .iResult(iResult),
    .qResult(qResult), .resultValid(resultValid), .resultReady(resultReady));
  padc_rx_model u_padc_rx_model (.clk(clk), .rst_b(rst_b), .stall(stall),
    .resultValid(resultValid), .iResult(iResult), .qResult(qResult),
    .resultReady(resultReady), .pairI(pairI), .pairQ(pairQ));

  always #5 clk = ~clk;

  // Overlapping stage weights: stage s counts at 2^(8-s); the sum saturates at full scale.
  function automatic logic [9:0] corrected(input logic [17:0] c);
    int sum;
    sum = 0;
    for (int s = 0; s < 9; s++) sum += int'(c[17-2*s -: 2]) << (8 - s);
    return (sum > 1023) ? 10'h3ff : sum[9:0];
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Codes are held steady so every pipeline slot carries the same sample.
  task automatic apply(input logic [17:0] ci, input logic [17:0] cq);
    iStageCode = ci;
    qStageCode = cq;
    repeat (8) begin
      @(negedge clk);
      stall = 1'($random(seed));
    end
    stall = 1'b0;
    repeat (14) @(negedge clk);
    repeat (3) begin
      @(negedge clk);
      check({9'h000, resultValid}, 10'h001);
    end
    check(iResult, corrected(ci));
    check(qResult, corrected(cq));
    check(pairI, corrected(ci));
    check(pairQ, corrected(cq));
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    check(iResult, 10'h000);
    check({9'h000, resultValid}, 10'h000);
    check({8'h00, phase}, {8'h00, padc_pkg::PADC_SAMPLE});
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) begin
      held = {8'h00, phase};
      @(negedge clk);
      check({9'h000, sampleEn}, {9'h000, phase == padc_pkg::PADC_SAMPLE});
      check({9'h000, held[1:0] != phase}, 10'h001);
    end
    for (int i = 0; i < 4; i++) begin
      apply(corner[i], corner[3-i]);
      check(iResult, cornerExp[i]);
      check(qResult, cornerExp[3-i]);
    end
    // Only the flash stage changes, so the new word shows exactly after six edges.
    apply(18'h20000, 18'h00000);
    iStageCode = 18'h20001;
    repeat (5) @(negedge clk);
    check(iResult, 10'h200);
    @(negedge clk);
    check(iResult, 10'h201);
    repeat (12) apply(18'($random(seed)), 18'($random(seed)));
    stall = 1'b1;
    repeat (2) @(negedge clk);
    held = iResult;
    iStageCode = ~iStageCode;
    repeat (10) @(negedge clk);
    check(iResult, held);
    apply(18'h2aaaa, 18'h0ffff);
    end_sim();
  end
endmodule
